/* File: rtl/lsr_lane_if.sv */
// per-channel link between the receive control and one receive lane
`timescale 1ns/1ps
interface lsr_lane_if;
    import lsr_pkg::*;
    logic [3:0]            factor;
    logic [2:0]            idx;
    logic                  last;
    logic                  cal;
    logic                  cal_start;
    logic                  ser;
    logic [LSR_LANE_W-1:0] word;
    logic                  done;

    modport ctl  (output factor, idx, last, cal, cal_start, ser, input word, done);
    modport lane (input factor, idx, last, cal, cal_start, ser, output word, done);
endinterface

/* File: rtl/lsr_pkg.sv */
// constants, types and helpers shared by the serdes block
package lsr_pkg;

    // ------------------------------------------------------------------
    // conversion modes and factors
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LSR_MODE_X1,
        LSR_MODE_X4,
        LSR_MODE_X7,
        LSR_MODE_X8
    } lsr_mode_t;

    localparam int          LSR_CHANNELS   = 16;
    localparam int          LSR_LANE_W     = 8;
    localparam int          LSR_BUS_W      = 128;
    localparam logic [3:0]  LSR_FAC_X1     = 4'h1;
    localparam logic [3:0]  LSR_FAC_X4     = 4'h4;
    localparam logic [3:0]  LSR_FAC_X7     = 4'h7;
    localparam logic [3:0]  LSR_FAC_X8     = 4'h8;
    localparam logic [3:0]  LSR_FAC_TX_X1  = 4'h8;

    // ------------------------------------------------------------------
    // rates of the highest-rate operation, in kHz
    // ------------------------------------------------------------------
    localparam int          LSR_FWD_KHZ    = 77760;
    localparam int          LSR_BIT_KHZ    = 622080;
    localparam int          LSR_X8_RATIO   = LSR_BIT_KHZ / LSR_FWD_KHZ;

    // ------------------------------------------------------------------
    // alignment and calibration
    // ------------------------------------------------------------------
    localparam int          LSR_RX_LAG     = 2;
    localparam logic [2:0]  LSR_CAL_ONE_X4 = 3'h2;
    localparam logic [2:0]  LSR_CAL_ONE_X7 = 3'h4;
    localparam logic [2:0]  LSR_CAL_ONE_X8 = 3'h4;
    localparam logic [1:0]  LSR_PHASE_MAX  = 2'h3;
    localparam logic [2:0]  LSR_IDX_RST    = 3'h0;
    localparam logic [2:0]  LSR_TX_IDX_RST = 3'h7;

    function automatic logic [3:0] lsr_factor(input lsr_mode_t m);
        case (m)
            LSR_MODE_X4: lsr_factor = LSR_FAC_X4;
            LSR_MODE_X7: lsr_factor = LSR_FAC_X7;
            LSR_MODE_X8: lsr_factor = LSR_FAC_X8;
            default:     lsr_factor = LSR_FAC_X1;
        endcase
    endfunction

endpackage

/* File: rtl/lsr_rx_lane.sv */
// one receive channel: phase pick, calibration and deserializer
`timescale 1ns/1ps
module lsr_rx_lane
    import lsr_pkg::*;
(
    input  wire logic   i_clk_sys,
    input  wire logic   i_nrst,
    lsr_lane_if.lane    lif
);

    logic [2:0]            hist_r,  hist_nxt;
    logic [1:0]            phase_r, phase_nxt;
    logic                  seen_r,  seen_nxt;
    logic [2:0]            first_r, first_nxt;
    logic                  done_r,  done_nxt;
    logic [LSR_LANE_W-1:0] acc_r,   acc_nxt;
    logic [LSR_LANE_W-1:0] word_r,  word_nxt;
    logic [3:0]            taps;
    logic                  sample;
    logic [2:0]            expect_one;
    logic [2:0]            late;

    assign taps   = {hist_r, lif.ser};
    assign sample = taps[phase_r];

    always_comb
    begin
        case (lif.factor)
            LSR_FAC_X4: expect_one = LSR_CAL_ONE_X4;
            LSR_FAC_X7: expect_one = LSR_CAL_ONE_X7;
            default:    expect_one = LSR_CAL_ONE_X8;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        hist_nxt  = {hist_r[1:0], lif.ser};
        phase_nxt = phase_r;
        seen_nxt  = seen_r;
        first_nxt = first_r;
        done_nxt  = done_r;
        acc_nxt   = acc_r;
        word_nxt  = word_r;
        late      = first_nxt - expect_one;
        if (lif.cal_start)
            done_nxt = 1'b0;
        if (lif.cal)
        begin
            // first one of the pattern marks this lane's lateness
            if (lif.idx == LSR_IDX_RST)
                seen_nxt = 1'b0;
            if (!seen_nxt && lif.ser)
            begin
                seen_nxt  = 1'b1;
                first_nxt = lif.idx;
            end
            late = first_nxt - expect_one;
            if (lif.last && seen_nxt)
            begin
                if (first_nxt < expect_one)
                    phase_nxt = 2'h0;
                else if (late > 3'(LSR_PHASE_MAX))
                    phase_nxt = LSR_PHASE_MAX;
                else
                    phase_nxt = late[1:0];
                done_nxt = 1'b1;
                seen_nxt = 1'b0;
            end
        end
        else
        begin
            // bit 0 earliest, lands in word bit 0
            if (lif.idx == LSR_IDX_RST)
                acc_nxt = '0;
            acc_nxt[lif.idx] = sample;
            if (lif.last)
                word_nxt = acc_nxt;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            hist_r  <= '0;
            phase_r <= '0;
            seen_r  <= 1'b0;
            first_r <= '0;
            done_r  <= 1'b0;
            acc_r   <= '0;
            word_r  <= '0;
        end
        else
        begin
            hist_r  <= hist_nxt;
            phase_r <= phase_nxt;
            seen_r  <= seen_nxt;
            first_r <= first_nxt;
            done_r  <= done_nxt;
            acc_r   <= acc_nxt;
            word_r  <= word_nxt;
        end
    end

    assign lif.word = word_r;
    assign lif.done = done_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_lane_cal_sets_done;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (lif.cal && lif.last && (seen_r || lif.ser)) |=> done_r;
    endproperty
    a_lane_cal_sets_done: assert property (p_lane_cal_sets_done)
        else $error("lane did not finish calibration");

    property p_lane_restart_clears;
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (lif.cal_start && !(lif.last && (seen_r || lif.ser))) |=> !done_r;
    endproperty
    a_lane_restart_clears: assert property (p_lane_restart_clears)
        else $error("lane done survived calibration restart");

endmodule // lsr_rx_lane

/* File: rtl/lsr_serdes.sv */
// serial receive and transmit converter with deskew and clock outputs
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
module lsr_serdes
    import lsr_pkg::*;
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_nrst,
    input  wire logic [1:0]              i_mode,
    input  wire logic                    i_fwd_clk,
    input  wire logic [LSR_CHANNELS-1:0] i_rx_ser,
    input  wire logic                    i_cal_req,
    input  wire logic                    i_tx_ext_clk,
    input  wire logic                    i_tx_ref_sel,
    input  wire logic [LSR_BUS_W-1:0]    i_tx_data,
    output logic [LSR_BUS_W-1:0]         o_rx_data,
    output logic                         o_rx_valid,
    output logic [LSR_CHANNELS-1:0]      o_rx_bypass,
    output logic                         o_rx_clk_1x,
    output logic                         o_rx_cal_done,
    output logic                         o_tx_ready,
    output logic [LSR_CHANNELS-1:0]      o_tx_ser,
    output logic                         o_tx_clk
);

    lsr_mode_t  mode;
    logic [3:0] rx_fac;
    logic [3:0] tx_fac;

    assign mode   = lsr_mode_t'(i_mode);
    assign rx_fac = lsr_factor(mode);
    assign tx_fac = (mode == LSR_MODE_X1) ? LSR_FAC_TX_X1 : rx_fac;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [LSR_CHANNELS-1:0] ser_s1_r, ser_s2_r;
    logic [2:0]              fwd_r, cal_r, ext_r;

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ser_s1_r <= '0;
            ser_s2_r <= '0;
            fwd_r    <= '0;
            cal_r    <= '0;
            ext_r    <= '0;
        end
        else
        begin
            ser_s1_r <= i_rx_ser;
            ser_s2_r <= ser_s1_r;
            fwd_r    <= {fwd_r[1:0], i_fwd_clk};
            cal_r    <= {cal_r[1:0], i_cal_req};
            ext_r    <= {ext_r[1:0], i_tx_ext_clk};
        end
    end

    logic fwd_edge;
    logic ext_edge;
    logic cal_start;
    assign fwd_edge  = fwd_r[1] & ~fwd_r[2];
    assign ext_edge  = ext_r[1] & ~ext_r[2];
    assign cal_start = cal_r[1] & ~cal_r[2];

    // ------------------------------------------------------------------
    // receive bit timing
    // ------------------------------------------------------------------
    logic [2:0]  rx_idx_r, rx_idx_nxt;
    logic        edge_d_r;
    logic        rx_last;
    logic        rx_valid_r, rx_valid_nxt;
    logic        rx_clk_r, rx_clk_nxt;
    logic        rx_done_r, rx_done_nxt;
    logic [LSR_CHANNELS-1:0] lane_done;
    logic [LSR_CHANNELS-1:0] bypass_r;

    assign rx_last = (mode != LSR_MODE_X1) && ({1'b0, rx_idx_r} == rx_fac - 4'h1);

    always_comb
    begin
        // bit 0 starts two bit periods after the forwarded edge
        if (edge_d_r)
            rx_idx_nxt = LSR_IDX_RST;
        else if (({1'b0, rx_idx_r} >= rx_fac - 4'h1) || (mode == LSR_MODE_X1))
            rx_idx_nxt = LSR_IDX_RST;
        else
            rx_idx_nxt = rx_idx_r + 3'h1;
        rx_valid_nxt = rx_last && !cal_r[1];
        if (mode == LSR_MODE_X1)
            rx_clk_nxt = fwd_r[1];
        else
            rx_clk_nxt = ({1'b0, rx_idx_nxt} < (rx_fac >> 1)) || (rx_idx_nxt == LSR_IDX_RST);
        rx_done_nxt = &lane_done;
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rx_idx_r   <= LSR_IDX_RST;
            edge_d_r   <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_clk_r   <= 1'b0;
            rx_done_r  <= 1'b0;
            bypass_r   <= '0;
        end
        else
        begin
            rx_idx_r   <= rx_idx_nxt;
            edge_d_r   <= fwd_edge;
            rx_valid_r <= rx_valid_nxt;
            rx_clk_r   <= rx_clk_nxt;
            rx_done_r  <= rx_done_nxt;
            bypass_r   <= ser_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // receive lanes
    // ------------------------------------------------------------------
    lsr_lane_if lif [LSR_CHANNELS] ();

    genvar g;
    generate
        for (g = 0; g < LSR_CHANNELS; g++)
        begin : g_lane
            assign lif[g].factor    = rx_fac;
            assign lif[g].idx       = rx_idx_r;
            assign lif[g].last      = rx_last;
            assign lif[g].cal       = cal_r[1];
            assign lif[g].cal_start = cal_start;
            assign lif[g].ser       = ser_s2_r[g];
            assign lane_done[g]     = lif[g].done;
            assign o_rx_data[g*LSR_LANE_W +: LSR_LANE_W] = lif[g].word;

            lsr_rx_lane u_lane (
                .i_clk_sys (i_clk_sys),
                .i_nrst    (i_nrst),
                .lif       (lif[g])
            );
        end
    endgenerate

    assign o_rx_valid    = rx_valid_r;
    assign o_rx_bypass   = bypass_r;
    assign o_rx_clk_1x   = rx_clk_r;
    assign o_rx_cal_done = rx_done_r;

    // ------------------------------------------------------------------
    // transmit bit timing and serializer
    // ------------------------------------------------------------------
    logic [2:0]              tx_idx_r, tx_idx_nxt;
    logic [LSR_BUS_W-1:0]    tx_word_r, tx_word_nxt;
    logic [LSR_CHANNELS-1:0] tx_ser_r, tx_ser_nxt;
    logic                    tx_clk_r, tx_clk_nxt;
    logic                    tx_ref_edge;

    assign tx_ref_edge = i_tx_ref_sel ? edge_d_r : ext_edge;

    always_comb
    begin
        logic [LSR_LANE_W-1:0] w8;
        w8 = '0;
        if (tx_ref_edge || ({1'b0, tx_idx_r} >= tx_fac - 4'h1))
            tx_idx_nxt = LSR_IDX_RST;
        else
            tx_idx_nxt = tx_idx_r + 3'h1;
        tx_word_nxt = (tx_idx_nxt == LSR_IDX_RST) ? i_tx_data : tx_word_r;
        for (int c = 0; c < LSR_CHANNELS; c++)
        begin
            w8 = tx_word_nxt[c*LSR_LANE_W +: LSR_LANE_W];
            tx_ser_nxt[c] = w8[tx_idx_nxt];
        end
        tx_clk_nxt = ({1'b0, tx_idx_nxt} < (tx_fac >> 1));
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            tx_idx_r  <= LSR_TX_IDX_RST;
            tx_word_r <= '0;
            tx_ser_r  <= '0;
            tx_clk_r  <= 1'b0;
        end
        else
        begin
            tx_idx_r  <= tx_idx_nxt;
            tx_word_r <= tx_word_nxt;
            tx_ser_r  <= tx_ser_nxt;
            tx_clk_r  <= tx_clk_nxt;
        end
    end

    assign o_tx_ready = (tx_idx_nxt == LSR_IDX_RST);
    assign o_tx_ser   = tx_ser_r;
    assign o_tx_clk   = tx_clk_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_fwd_edge;
        fwd_edge && (mode != LSR_MODE_X1);
    endsequence

    property p_rx_lag;
        s_fwd_edge |-> ##2 (rx_idx_r == LSR_IDX_RST);
    endproperty
    a_rx_lag: assert property (p_rx_lag)
        else $error("bit 0 not two bit periods after forwarded edge");

    property p_rx_idx_bound;
        (mode != LSR_MODE_X1) |-> ({1'b0, rx_idx_r} < rx_fac);
    endproperty
    a_rx_idx_bound: assert property (p_rx_idx_bound)
        else $error("receive bit index beyond factor");

    property p_rx_valid;
        (rx_last && !cal_r[1]) |=> o_rx_valid;
    endproperty
    a_rx_valid: assert property (p_rx_valid)
        else $error("word not presented after last bit");

    property p_rx_clk_1x;
        (mode != LSR_MODE_X1 && rx_idx_nxt == LSR_IDX_RST) |=> o_rx_clk_1x;
    endproperty
    a_rx_clk_1x: assert property (p_rx_clk_1x)
        else $error("1x clock low at frame start");

    property p_x8_ratio;
        (mode == LSR_MODE_X8) |-> (rx_fac == 4'(LSR_X8_RATIO)) && (tx_fac == 4'(LSR_X8_RATIO));
    endproperty
    a_x8_ratio: assert property (p_x8_ratio)
        else $error("x8 factor does not match the line rate ratio");

    property p_cal_done;
        $rose(o_rx_cal_done) |-> $past(&lane_done);
    endproperty
    a_cal_done: assert property (p_cal_done)
        else $error("calibration done before all lanes");

    property p_tx_bit0_clk;
        (tx_idx_r == LSR_IDX_RST) |-> o_tx_clk;
    endproperty
    a_tx_bit0_clk: assert property (p_tx_bit0_clk)
        else $error("bit 0 not with transmit clock high");

    sequence s_tx_load;
        o_tx_ready ##1 (tx_idx_r == LSR_IDX_RST);
    endsequence

    property p_tx_load;
        o_tx_ready |=> (o_tx_ser[0] == $past(i_tx_data[0])) && o_tx_clk;
    endproperty
    a_tx_load: assert property (p_tx_load)
        else $error("loaded bit 0 not launched in phase with clock");

    property p_tx_frame;
        (o_tx_ready && tx_fac == LSR_FAC_X8 && !tx_ref_edge) |-> s_tx_load;
    endproperty
    a_tx_frame: assert property (p_tx_frame)
        else $error("transmit frame did not restart after load");

endmodule // lsr_serdes

/* File: tb/lsr_far_end.sv */
// far-end serial device model: forwarded clock, lane data, deskew request
`timescale 1ns/1ps
module lsr_far_end
    import lsr_pkg::*;
(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_en,
    input  wire logic                 i_cal_go,
    input  wire logic [3:0]           i_factor,
    input  wire logic [LSR_BUS_W-1:0] i_word,
    output logic                      o_fwd_clk,
    output logic [LSR_CHANNELS-1:0]   o_ser,
    output logic                      o_cal_req
);
    int cnt    = 0;
    int frames = 0;
    int fac;
    int n;
    int s;

    initial
    begin
        o_fwd_clk = 1'b0;
        o_ser     = '0;
        o_cal_req = 1'b0;
    end

    // ------------------------------------------------------------------
    // one bit slot per clock
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys)
    begin
        fac = int'(i_factor);
        n   = (cnt + 1) % fac;
        s   = o_cal_req ? n : (n + fac - 2) % fac;
        if (!i_en)
        begin
            o_fwd_clk <= 1'b0;
            o_ser     <= ~o_ser;
            cnt       <= 0;
        end
        else
        begin
            cnt       <= n;
            o_fwd_clk <= (n < fac / 2);
            for (int c = 0; c < LSR_CHANNELS; c++)
                o_ser[c] <= o_cal_req ? (s >= fac - (fac == 4 ? 2 : fac == 7 ? 3 : 4))
                                      : i_word[8*c+s];
            if (n == fac / 2)
            begin
                frames    <= o_cal_req ? frames + 1 : 0;
                o_cal_req <= o_cal_req ? (frames < 3) : i_cal_go;
            end
        end
    end
endmodule // lsr_far_end

/* File: tb/tb.sv */
// self-checking testbench of the serdes block
`timescale 1ns/1ps
module tb
    import lsr_pkg::*;
;
    typedef struct {
        logic [1:0]   m;
        logic [127:0] w;
    } lsr_row_t;

    logic                    clk;
    logic                    nrst;
    logic [1:0]              mode;
    logic [LSR_BUS_W-1:0]    word;
    logic [LSR_BUS_W-1:0]    tx_data;
    logic                    en;
    logic                    cal_go;
    logic                    ext_clk;
    logic                    ref_sel;
    logic                    fwd;
    logic [LSR_CHANNELS-1:0] ser;
    logic                    cal_req;
    logic [LSR_BUS_W-1:0]    rx_data;
    logic                    rx_valid;
    logic [LSR_CHANNELS-1:0] rx_bypass;
    logic                    rx_clk_1x;
    logic                    cal_done;
    logic                    tx_ready;
    logic [LSR_CHANNELS-1:0] tx_ser;
    logic                    tx_clk;
    int                      errors      = 0;
    int                      check_count = 0;
    int                      facs[4]     = '{8, 4, 7, 8};
    lsr_row_t                rows[5]     = '{
        '{2'h1, 128'h0123456789abcdeffedcba9876543210},
        '{2'h2, 128'h5a3c96e10ff0a55a1234abcd8765dcba},
        '{2'h3, 128'hdeadbeef0f1e2d3c4b5a69788796a5b4},
        '{2'h0, 128'hc3d2e1f0a5a5a5a55aa5f00f3cc36996},
        '{2'h3, 128'h00ff807f01fe40bf02fd20df04fb10ef}
    };

    lsr_serdes lsr_serdes_i (
        .i_clk_sys     (clk),
        .i_nrst        (nrst),
        .i_mode        (mode),
        .i_fwd_clk     (fwd),
        .i_rx_ser      (ser),
        .i_cal_req     (cal_req),
        .i_tx_ext_clk  (ext_clk),
        .i_tx_ref_sel  (ref_sel),
        .i_tx_data     (tx_data),
        .o_rx_data     (rx_data),
        .o_rx_valid    (rx_valid),
        .o_rx_bypass   (rx_bypass),
        .o_rx_clk_1x   (rx_clk_1x),
        .o_rx_cal_done (cal_done),
        .o_tx_ready    (tx_ready),
        .o_tx_ser      (tx_ser),
        .o_tx_clk      (tx_clk)
    );

    lsr_far_end lsr_far_end_i (
        .i_clk_sys (clk),
        .i_en      (en),
        .i_cal_go  (cal_go),
        .i_factor  (4'(facs[mode])),
        .i_word    (word),
        .o_fwd_clk (fwd),
        .o_ser     (ser),
        .o_cal_req (cal_req)
    );

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic reset_check;
        check(rx_data, '0);
        check({rx_valid, cal_done, tx_clk, tx_ready, tx_ser}, 20'h10000);
    endtask

    task automatic wait_valid(output int gap, output int highs);
        gap   = 0;
        highs = 0;
        do
        begin
            tick;
            gap++;
            highs += (rx_clk_1x === 1'b1);
        end
        while (rx_valid !== 1'b1 && gap < 60);
        check(rx_valid, 1'b1);
    endtask

    initial
    begin
        #2000000;
        errors++;
        final_report;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int f;
        int t;
        int gap;
        int highs;
        logic [127:0] exp;
        logic [15:0]  e16;
        logic [15:0]  h[3];
        nrst    = 1'b0;
        mode    = 2'h3;
        word    = '0;
        tx_data = '0;
        en      = 1'b1;
        cal_go  = 1'b0;
        ext_clk = 1'b0;
        ref_sel = 1'b0;
        repeat (2) tick;
        reset_check;
        tick;
        nrst = 1'b1;
        for (int r = 0; r < 5; r++)
        begin
            mode    = rows[r].m;
            word    = rows[r].w;
            tx_data = ~rows[r].w;
            f       = facs[mode];
            repeat (24) tick;
            t = 0;
            while (tx_ready !== 1'b1 && t < 20)
            begin
                tick;
                t++;
            end
            check(tx_ready, 1'b1);
            for (int k = 0; k < f; k++)
            begin
                tick;
                for (int c = 0; c < 16; c++)
                    e16[c] = tx_data[8*c+k];
                check(tx_ser, e16);
                check(tx_clk, k < f / 2);
                check(tx_ready, k == f - 1);
            end
            if (mode == 2'h0)
            begin
                for (int i = 0; i < 12; i++)
                begin
                    tick;
                    if (i >= 3)
                        check(rx_bypass, h[2]);
                    check(rx_valid, 1'b0);
                    h[2] = h[1];
                    h[1] = h[0];
                    h[0] = ser;
                end
            end
            else
            begin
                exp = '0;
                for (int c = 0; c < 16; c++)
                    for (int k = 0; k < f; k++)
                        exp[8*c+k] = word[8*c+k];
                wait_valid(gap, highs);
                wait_valid(gap, highs);
                wait_valid(gap, highs);
                check(gap, f);
                check(highs, f / 2);
                check(rx_data, exp);
            end
        end
        mode   = 2'h3;
        // external reference edge restarts the transmit frame
        t = 0;
        while (tx_ready !== 1'b1 && t < 20)
        begin
            tick;
            t++;
        end
        ext_clk = 1'b1;
        repeat (2) tick;
        check(tx_ready, 1'b1);
        tick;
        ext_clk = 1'b0;
        check(tx_clk, 1'b1);
        repeat (7) tick;
        check(tx_ready, 1'b1);
        // transmit frame follows receive frame timing
        ref_sel = 1'b1;
        repeat (16) tick;
        for (int i = 0; i < 8; i++)
        begin
            tick;
            check(tx_clk, rx_clk_1x);
        end
        ref_sel = 1'b0;
        cal_go = 1'b1;
        t      = 0;
        while (cal_done !== 1'b1 && t < 300)
        begin
            tick;
            t++;
        end
        check(cal_done, 1'b1);
        cal_go = 1'b0;
        repeat (40) tick;
        check(cal_done, 1'b1);
        // a new request clears done until the lanes calibrate again
        cal_go = 1'b1;
        t      = 0;
        while (cal_done !== 1'b0 && t < 40)
        begin
            tick;
            t++;
        end
        check(cal_done, 1'b0);
        cal_go = 1'b0;
        t      = 0;
        while (cal_done !== 1'b1 && t < 300)
        begin
            tick;
            t++;
        end
        check(cal_done, 1'b1);
        nrst = 1'b0;
        #1;
        reset_check;
        repeat (3) tick;
        nrst = 1'b1;
        tick;
        for (int c = 0; c < 16; c++)
            e16[c] = tx_data[8*c];
        check(tx_clk, 1'b1);
        check(tx_ser, e16);
        check(tx_ready, 1'b0);
        repeat (3) tick;
        final_report;
    end
endmodule // tb
